/* rtl/pbr_register_bank.sv */
`timescale 1ns/1ns
`include "pbr_consts.svh"
module pbr_register_bank
   import pbr_pkg::*;
#(
   parameter int POLL_GAP_CYC = `POLL_GAP_US * `MCLK_MHZ,
   parameter int I2C_TMO_CYC  = `I2C_TMO_US * `MCLK_MHZ
) (
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   input  wire logic        BUS_ADDR_SELECT,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE,
   output logic             ALERT_O,
   output logic             ALERT_OE,
   output logic [7:0]       PECI_RETRIES,
   output logic [7:0]       PECI_BIT_TIME,
   input  wire logic        PECI_CLK,
   input  wire logic        PECI_DONE,
   input  wire logic [15:0] PECI_RESULT,
   output logic             PECI_RD_REQ,
   output logic [2:0]       PECI_RD_IDX
);

   function automatic logic is_err(input logic [15:0] t);
      return t[15:9] == `ERR_CODE_HI;
   endfunction

   // Internal values stay 16-bit; conversion and offset happen on the way out
   function automatic logic [15:0] fmt(input logic [15:0] t, input logic alt,
                                       input logic [15:0] offs);
      logic [15:0] v;
      v = alt ? {{9{t[15]}}, t[12:6]} : t;
      if (is_err(t)) begin
         return t;
      end
      return v + offs;
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] dly_mult(input logic [2:0] code);
      case (code)
         3'h1:    return `DLY_MULT_1;
         3'h2:    return `DLY_MULT_2;
         3'h3:    return `DLY_MULT_3;
         3'h4:    return `DLY_MULT_4;
         3'h5:    return `DLY_MULT_5;
         3'h6:    return `DLY_MULT_6;
         default: return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   logic [1:0] asel_s_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       i2c_start;
   logic       i2c_stop;

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         asel_s_q <= 2'h0;
      end else begin
         scl_s_q <= {scl_s_q[1:0], SCL_I};
         sda_s_q <= {sda_s_q[1:0], SDA_I};
         asel_s_q <= {asel_s_q[0], BUS_ADDR_SELECT};
      end
   end

   assign scl_rise  = scl_s_q[1] & ~scl_s_q[2];
   assign scl_fall  = ~scl_s_q[1] & scl_s_q[2];
   assign i2c_start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
   assign i2c_stop  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [15:0] main_cfg_q;
   logic [15:0] retry_cfg_q;
   logic [15:0] offs_cfg_q;
   logic [15:0] avg_cfg_q;
   logic [15:0] limit_q [4];
   logic [15:0] temp_q  [8];
   logic [15:0] temp_fmt [8];
   logic [15:0] max_q;
   logic [15:0] max_loc_q;
   logic [15:0] alert_src_q;
   logic        alert_q;
   logic        wr_commit;
   logic [7:0]  cmd_q;
   logic [15:0] wdata;
   logic        res_evt;
   logic [15:0] res_data_q;
   logic [2:0]  idx_q;
   logic        poll_cmd;
   logic        clr_cmd;

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         main_cfg_q  <= `MAIN_CFG_RST;
         retry_cfg_q <= `RETRY_CFG_RST;
         offs_cfg_q  <= `OFFS_CFG_RST;
         avg_cfg_q   <= `AVG_CFG_RST;
         for (int i = 0; i < 4; i++) begin
            limit_q[i] <= `LIMIT_RST;
         end
      end else if (wr_commit) begin
         case (cmd_q)
            `CMD_MAIN_CFG: begin
               main_cfg_q <= wdata & `MAIN_CFG_WMASK;
               if (wdata[`BIT_ALT_FMT] != main_cfg_q[`BIT_ALT_FMT]) begin
                  offs_cfg_q <= wdata[`BIT_ALT_FMT] ?
                     16'($signed(offs_cfg_q) >>> `ALT_SHIFT) : offs_cfg_q << `ALT_SHIFT;
               end
            end
            `CMD_RETRY_CFG: retry_cfg_q <= wdata;
            `CMD_OFFS_CFG:  offs_cfg_q  <= wdata;
            `CMD_AVG_CFG:   avg_cfg_q   <= wdata & `AVG_CFG_WMASK;
            default: begin
               if (cmd_q >= `CMD_LIMIT_S0 && cmd_q <= `CMD_LIMIT_S3) begin
                  limit_q[cmd_q[1:0]] <= wdata;
               end
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      PECI_RETRIES  <= retry_cfg_q[7:0];
      PECI_BIT_TIME <= retry_cfg_q[15:8];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temperature store, one entry per socket/domain
   logic [8:0] upd_q;
   genvar g;
   for (g = 0; g < 8; g++) begin : g_temp
      logic [16:0] diff;
      assign diff = 17'($signed(res_data_q)) - 17'($signed(temp_q[g]));
      always_ff @(posedge MCLK) begin
         if (!RSTN) begin
            temp_q[g] <= `TEMP_RST;
         end else if (res_evt && idx_q == 3'(g)) begin
            if (avg_cfg_q[7:0] == 8'h00 || is_err(res_data_q) || is_err(temp_q[g])) begin
               temp_q[g] <= res_data_q;
            end else begin
               // Precision is lost for large shift counts, as for any IIR of this form
               temp_q[g] <= temp_q[g] + 16'($signed(diff) >>> avg_cfg_q[7:0]);
            end
         end
      end
      assign temp_fmt[g] = fmt(temp_q[g], main_cfg_q[`BIT_ALT_FMT], offs_cfg_q);
   end

   // Maximum over enabled pairs, recomputed every cycle
   logic [15:0] max_d;
   logic [15:0] max_loc_d;
   always_comb begin
      max_d     = 16'h0000;
      max_loc_d = `NO_MAX_LOC;
      for (int i = 0; i < 8; i++) begin
         if (main_cfg_q[`POLL_EN_LSB + i] && !is_err(temp_q[i]) &&
             (max_loc_d == `NO_MAX_LOC || $signed(temp_fmt[i]) > $signed(max_d))) begin
            max_d     = temp_fmt[i];
            max_loc_d = 16'(i);
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         max_q     <= 16'h0000;
         max_loc_q <= `NO_MAX_LOC;
      end else begin
         max_q     <= max_d;
         max_loc_q <= max_loc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alert: compared the cycle after the store so averaging is included
   logic over;
   assign over = !is_err(temp_q[idx_q]) &&
                 $signed(temp_fmt[idx_q]) > $signed(limit_q[idx_q[2:1]]);

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         upd_q       <= 9'h000;
         alert_q     <= 1'b0;
         alert_src_q <= 16'h0000;
         ALERT_O     <= 1'b0;
         ALERT_OE    <= 1'b0;
      end else begin
         upd_q <= {res_evt, 8'h00};
         if (upd_q[8] && over && !main_cfg_q[`BIT_ALERT_MASK]) begin
            alert_q <= 1'b1;
            if (!alert_q || clr_cmd) begin
               alert_src_q <= 16'(idx_q);
            end
         end else if (clr_cmd) begin
            alert_q     <= 1'b0;
            alert_src_q <= 16'h0000;
         end
         ALERT_O  <= 1'b0;
         ALERT_OE <= alert_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Poll scheduler
   pbr_sched_state_t sch_q;
   logic [19:0]      tick_q;
   logic [7:0]       mult_q;
   logic             poll_pend_q;
   logic             req_tog_q;
   logic             tick_end;
   logic [7:0]       mult_cfg;

   assign tick_end = tick_q == 20'(POLL_GAP_CYC - 1);
   assign mult_cfg = dly_mult(main_cfg_q[2:0]);

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         sch_q       <= SCH_IDLE;
         tick_q      <= 20'h00000;
         mult_q      <= 8'h00;
         idx_q       <= 3'h0;
         poll_pend_q <= 1'b0;
         req_tog_q   <= 1'b0;
      end else begin
         if (poll_cmd) begin
            poll_pend_q <= 1'b1;
         end
         case (sch_q)
            SCH_IDLE: begin
               idx_q  <= 3'h0;
               tick_q <= 20'h00000;
               mult_q <= 8'h00;
               if (poll_pend_q) begin
                  poll_pend_q <= poll_cmd;
                  sch_q       <= SCH_SCAN;
               end else if (mult_cfg != 8'h00) begin
                  sch_q <= SCH_DELAY;
               end
            end
            SCH_SCAN: begin
               if (main_cfg_q[`POLL_EN_LSB + 32'(idx_q)]) begin
                  req_tog_q <= ~req_tog_q;
                  sch_q     <= SCH_WAIT;
               end else if (idx_q == 3'h7) begin
                  sch_q <= SCH_IDLE;
               end else begin
                  idx_q <= idx_q + 3'h1;
               end
            end
            SCH_WAIT: begin
               if (res_evt) begin
                  sch_q <= SCH_GAP;
               end
            end
            SCH_GAP: begin
               tick_q <= tick_end ? 20'h00000 : tick_q + 20'h00001;
               if (tick_end) begin
                  if (idx_q == 3'h7) begin
                     sch_q <= SCH_IDLE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                     sch_q <= SCH_SCAN;
                  end
               end
            end
            SCH_DELAY: begin
               tick_q <= tick_end ? 20'h00000 : tick_q + 20'h00001;
               if (tick_end) begin
                  mult_q <= mult_q + 8'h01;
               end
               // A request cuts the pause short; a code change to 0 ends it
               if (poll_pend_q || mult_cfg == 8'h00 || (tick_end && mult_q + 8'h01 >= mult_cfg)) begin
                  sch_q <= SCH_IDLE;
                  if (!poll_pend_q && mult_cfg != 8'h00) begin
                     poll_pend_q <= 1'b1;
                  end
               end
            end
            default: sch_q <= SCH_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: request toggle in, result toggle out
   logic [1:0]  lrst_q;
   logic [2:0]  lreq_s_q;
   logic        ldone_tog_q;
   logic [15:0] lres_q;

   always_ff @(posedge PECI_CLK) begin
      lrst_q <= {lrst_q[0], RSTN};
   end

   always_ff @(posedge PECI_CLK) begin
      if (!lrst_q[1]) begin
         lreq_s_q    <= 3'h0;
         PECI_RD_REQ <= 1'b0;
         PECI_RD_IDX <= 3'h0;
         ldone_tog_q <= 1'b0;
         lres_q      <= 16'h0000;
      end else begin
         lreq_s_q    <= {lreq_s_q[1:0], req_tog_q};
         PECI_RD_REQ <= lreq_s_q[1] ^ lreq_s_q[2];
         if (lreq_s_q[1] ^ lreq_s_q[2]) begin
            PECI_RD_IDX <= idx_q; // Stable since the toggle left the core
         end
         if (PECI_DONE) begin
            lres_q      <= PECI_RESULT;
            ldone_tog_q <= ~ldone_tog_q;
         end
      end
   end

   logic [2:0] done_s_q;
   logic       res_new_q;
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         done_s_q   <= 3'h0;
         res_data_q <= 16'h0000;
         res_new_q  <= 1'b0;
      end else begin
         done_s_q  <= {done_s_q[1:0], ldone_tog_q};
         res_new_q <= done_s_q[1] ^ done_s_q[2];
         if (done_s_q[1] ^ done_s_q[2]) begin
            res_data_q <= lres_q; // Held by the link side until the next result
         end
      end
   end
   assign res_evt = res_new_q && sch_q == SCH_WAIT;

   ////////////////////////////////////////////////////////////////////////////
   // SMBus slave
   pbr_i2c_state_t i2c_q;
   pbr_i2c_state_t nxt_q;
   logic [7:0]     shift_q;
   logic [2:0]     bit_q;
   logic [1:0]     byte_q;
   logic [7:0]     crc_q;
   logic [7:0]     tx_q;
   logic [15:0]    rword_q;
   logic [7:0]     wlo_q;
   logic [7:0]     whi_q;
   logic           got8_q;
   logic           mack_q;
   logic [21:0]    tmo_q;
   logic [7:0]     rx;
   logic [7:0]     crc_rx;
   logic [15:0]    rd_mux;
   logic           pec_en;

   assign rx     = {shift_q[6:0], sda_s_q[1]};
   assign crc_rx = crc8(crc_q, rx);
   assign pec_en = main_cfg_q[`BIT_PEC_EN];
   assign wdata  = {pec_en ? whi_q : rx, wlo_q};
   assign wr_commit = scl_rise && i2c_q == I2C_WDATA && bit_q == 3'h7 &&
                      ((byte_q == 2'h1 && !pec_en) || (byte_q == 2'h2 && pec_en && crc_rx == 8'h00)) &&
                      cmd_q >= `CMD_MAIN_CFG && cmd_q <= `CMD_LIMIT_S3;
   assign poll_cmd = scl_rise && i2c_q == I2C_CMD && bit_q == 3'h7 && rx == `CMD_POLL_REQ;
   assign clr_cmd  = scl_rise && i2c_q == I2C_CMD && bit_q == 3'h7 && rx == `CMD_CLR_ALERT;

   always_comb begin
      case (cmd_q)
         `CMD_MAX_TEMP:  rd_mux = max_q;
         `CMD_FW_VER:    rd_mux = `FW_VERSION;
         `CMD_MAX_LOC:   rd_mux = max_loc_q;
         `CMD_ALERT_SRC: rd_mux = alert_src_q;
         `CMD_MAIN_CFG:  rd_mux = main_cfg_q;
         `CMD_RETRY_CFG: rd_mux = retry_cfg_q;
         `CMD_OFFS_CFG:  rd_mux = offs_cfg_q;
         `CMD_AVG_CFG:   rd_mux = avg_cfg_q;
         default: begin
            if (cmd_q <= `CMD_TEMP_LAST) begin
               rd_mux = temp_fmt[cmd_q[2:0]];
            end else if (cmd_q >= `CMD_LIMIT_S0 && cmd_q <= `CMD_LIMIT_S3) begin
               rd_mux = limit_q[cmd_q[1:0]];
            end else begin
               rd_mux = 16'h0000;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         i2c_q   <= I2C_IDLE;
         nxt_q   <= I2C_IDLE;
         shift_q <= 8'h00;
         bit_q   <= 3'h0;
         byte_q  <= 2'h0;
         crc_q   <= 8'h00;
         tx_q    <= 8'h00;
         rword_q <= 16'h0000;
         wlo_q   <= 8'h00;
         whi_q   <= 8'h00;
         got8_q  <= 1'b0;
         cmd_q   <= 8'h00;
         mack_q  <= 1'b0;
         tmo_q   <= 22'h000000;
         SDA_O   <= 1'b0;
         SDA_OE  <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
         tmo_q <= (scl_s_q[1] || i2c_q == I2C_IDLE) ? 22'h000000 : tmo_q + 22'h000001;
         if (main_cfg_q[`BIT_TMO_EN] && tmo_q == 22'(I2C_TMO_CYC - 1)) begin
            i2c_q  <= I2C_IDLE;
            SDA_OE <= 1'b0;
         end else if (i2c_stop) begin
            i2c_q  <= I2C_IDLE;
            SDA_OE <= 1'b0;
         end else if (i2c_start) begin
            if (i2c_q == I2C_IDLE) begin
               crc_q <= 8'h00;
            end
            i2c_q  <= I2C_ADDR;
            bit_q  <= 3'h0;
            SDA_OE <= 1'b0;
         end else if (scl_rise) begin
            shift_q <= rx;
            bit_q   <= bit_q + 3'h1;
            got8_q  <= bit_q == 3'h7;
            if (bit_q == 3'h7) begin
               case (i2c_q)
                  I2C_ADDR: begin
                     crc_q <= crc_rx;
                     if (rx[7:1] != {`I2C_BASE_ADDR, asel_s_q[1]}) begin
                        i2c_q <= I2C_IDLE;
                     end else if (rx[0]) begin
                        nxt_q   <= I2C_RDATA;
                        rword_q <= rd_mux;
                        tx_q    <= rd_mux[7:0];
                        byte_q  <= 2'h0;
                     end else begin
                        nxt_q <= I2C_CMD;
                     end
                  end
                  I2C_CMD: begin
                     crc_q  <= crc_rx;
                     cmd_q  <= rx;
                     byte_q <= 2'h0;
                     nxt_q  <= I2C_WDATA;
                  end
                  I2C_WDATA: begin
                     crc_q  <= crc_rx;
                     wlo_q  <= (byte_q == 2'h0) ? rx : wlo_q;
                     whi_q  <= (byte_q == 2'h1) ? rx : whi_q;
                     byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
                     nxt_q  <= I2C_WDATA;
                  end
                  I2C_RDATA: crc_q <= crc8(crc_q, tx_q);
                  I2C_RACK:  mack_q <= ~sda_s_q[1];
                  default: ;
               endcase
            end
            if (i2c_q == I2C_RACK) begin
               mack_q <= ~sda_s_q[1];
            end
         end else if (scl_fall) begin
            case (i2c_q)
               I2C_ADDR, I2C_CMD, I2C_WDATA: begin
                  if (got8_q) begin
                     SDA_OE <= 1'b1;
                     i2c_q  <= I2C_ACK;
                  end
               end
               I2C_ACK: begin
                  i2c_q  <= nxt_q;
                  bit_q  <= 3'h0;
                  SDA_OE <= (nxt_q == I2C_RDATA) ? ~tx_q[7] : 1'b0;
               end
               I2C_RDATA: begin
                  SDA_OE <= (bit_q == 3'h0) ? 1'b0 : ~tx_q[3'h7 - bit_q];
                  if (bit_q == 3'h0) begin
                     i2c_q <= I2C_RACK;
                  end
               end
               I2C_RACK: begin
                  bit_q <= 3'h0;
                  if (mack_q && (byte_q == 2'h0 || (byte_q == 2'h1 && pec_en))) begin
                     tx_q   <= (byte_q == 2'h0) ? rword_q[15:8] : crc_q;
                     SDA_OE <= (byte_q == 2'h0) ? ~rword_q[15] : ~crc_q[7];
                     byte_q <= byte_q + 2'h1;
                     i2c_q  <= I2C_RDATA;
                  end else begin
                     i2c_q <= I2C_IDLE;
                  end
               end
               default: ;
            endcase
         end
      end
   end

endmodule

/* pkg/pbr_consts.svh */
`ifndef PBR_CONSTS_SVH
`define PBR_CONSTS_SVH

`define CMD_TEMP_LAST  8'h07
`define CMD_MAX_TEMP   8'h08
`define CMD_FW_VER     8'h09
`define CMD_MAX_LOC    8'h0a
`define CMD_ALERT_SRC  8'h0b
`define CMD_MAIN_CFG   8'h0c
`define CMD_RETRY_CFG  8'h0d
`define CMD_OFFS_CFG   8'h0e
`define CMD_AVG_CFG    8'h0f
`define CMD_LIMIT_S0   8'h10
`define CMD_LIMIT_S3   8'h13
`define CMD_POLL_REQ   8'h14
`define CMD_CLR_ALERT  8'h15

`define MAIN_CFG_RST   16'h00a5
`define MAIN_CFG_WMASK 16'hfff7
`define RETRY_CFG_RST  16'h0203
`define OFFS_CFG_RST   16'h0000
`define AVG_CFG_RST    16'h0000
`define AVG_CFG_WMASK  16'h00ff
`define LIMIT_RST      16'h7fff
`define TEMP_RST       16'h0000
`define NO_MAX_LOC     16'h00ff

`define BIT_TMO_EN     7
`define BIT_ALT_FMT    6
`define BIT_PEC_EN     5
`define BIT_ALERT_MASK 4
`define POLL_EN_LSB    8
`define ERR_CODE_HI    7'h40
`define ALT_SHIFT      6

`define MCLK_MHZ       125
`define POLL_GAP_US    2500
`define I2C_TMO_US     25000
`define DLY_MULT_1     8'd1
`define DLY_MULT_2     8'd2
`define DLY_MULT_3     8'd4
`define DLY_MULT_4     8'd20
`define DLY_MULT_5     8'd40
`define DLY_MULT_6     8'd200

`define CRC_POLY       8'h07
`define I2C_BASE_ADDR  6'h2a
`define FW_VERSION     16'h0001

`endif

/* pkg/pbr_pkg.sv */
package pbr_pkg;
   typedef enum logic [3:0] {
      I2C_IDLE  = 4'b0000,
      I2C_ADDR  = 4'b0001,
      I2C_CMD   = 4'b0010,
      I2C_WDATA = 4'b0011,
      I2C_ACK   = 4'b0100,
      I2C_RDATA = 4'b0101,
      I2C_RACK  = 4'b0110
   } pbr_i2c_state_t;

   typedef enum logic [2:0] {
      SCH_IDLE  = 3'b000,
      SCH_SCAN  = 3'b001,
      SCH_WAIT  = 3'b010,
      SCH_GAP   = 3'b011,
      SCH_DELAY = 3'b100
   } pbr_sched_state_t;
endpackage

/* verif/pbr_register_bank_monitor.sv */
`timescale 1ns/1ns
module pbr_register_bank_monitor #(
   parameter int POLL_GAP_CYC = 50
) (
   input wire logic       MCLK,
   input wire logic       RSTN,
   input wire logic       SCL_I,
   input wire logic       SDA_O,
   input wire logic       SDA_OE,
   input wire logic       ALERT_O,
   input wire logic       ALERT_OE,
   input wire logic [7:0] PECI_RETRIES,
   input wire logic [7:0] PECI_BIT_TIME,
   input wire logic       PECI_CLK,
   input wire logic       PECI_DONE,
   input wire logic       PECI_RD_REQ
);
   logic [7:0]  scl_age_q;
   logic [7:0]  done_age_q;
   logic [15:0] req_age_q;
   logic        req_seen_q;
   ////////////////////////////////////////
   // Ages saturate so a long idle never wraps into a false recent event
   always_ff @(posedge MCLK) begin
      scl_age_q  <= $rose(SCL_I) ? 8'h00 : scl_age_q + {7'h00, scl_age_q != 8'hff};
      done_age_q <= PECI_DONE ? 8'h00 : done_age_q + {7'h00, done_age_q != 8'hff};
      req_age_q  <= $rose(PECI_RD_REQ) ? 16'h0000 : req_age_q + {15'h0, req_age_q != 16'hffff};
      req_seen_q <= RSTN & (req_seen_q | PECI_RD_REQ);
   end
   ////////////////////////////////////////
   sequence rel_s;
      $rose(RSTN) ##1 RSTN;
   endsequence
   rst_quiet_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      $rose(RSTN) |-> !ALERT_OE && !SDA_OE) else $error("output driven out of reset");
   link_defaults_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      rel_s |-> PECI_RETRIES == 8'h03 && PECI_BIT_TIME == 8'h02) else $error("link defaults");
   open_drain_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      ALERT_O == 1'b0 && SDA_O == 1'b0) else $error("open-drain pin driven high");
   alert_cause_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      $rose(ALERT_OE) |-> done_age_q < 8'd40) else $error("alert without a new reading");
   alert_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      $fell(ALERT_OE) |-> scl_age_q < 8'd8) else $error("alert dropped without command");
   req_pulse_a: assert property (@(posedge PECI_CLK) disable iff (!RSTN)
      PECI_RD_REQ |=> !PECI_RD_REQ) else $error("read request longer than one cycle");
   poll_gap_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      $rose(PECI_RD_REQ) && req_seen_q |-> req_age_q >= POLL_GAP_CYC) else $error("reads too close");
   sda_change_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      $changed(SDA_OE) |-> !SCL_I) else $error("data line moved while clock high");
endmodule
bind pbr_register_bank pbr_register_bank_monitor #(.POLL_GAP_CYC(POLL_GAP_CYC)) mon_u (
   .MCLK(MCLK), .RSTN(RSTN), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE), .PECI_RETRIES(PECI_RETRIES),
   .PECI_BIT_TIME(PECI_BIT_TIME), .PECI_CLK(PECI_CLK), .PECI_DONE(PECI_DONE),
   .PECI_RD_REQ(PECI_RD_REQ));

/* verif/pbr_host_model.sv */
`timescale 1ns/1ns
module pbr_host_model (
   output logic     scl,
   output logic     sda,
   input wire logic sda_oe
);
   logic pull_q;
   // Pulled-up wire: released means high, never the last driven value
   assign sda = !(pull_q | sda_oe);
   initial begin
      scl = 1'b1;
      pull_q = 1'b0;
   end
   ////////////////////////////////////////
   // Data moves 40 ns after the clock falls, clear of the input synchroniser
   task automatic bit_io(input logic b, output logic r);
      pull_q = !b;
      #40 scl = 1'b1;
      #40 r = sda;
      scl = 1'b0;
      #40;
   endtask
   task automatic start();
      pull_q = 1'b0;
      #40 scl = 1'b1;
      #40 pull_q = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic stop();
      pull_q = 1'b1;
      #40 scl = 1'b1;
      #40 pull_q = 1'b0;
      #40;
   endtask
   task automatic byte_w(input logic [7:0] b, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, ak);
   endtask
   task automatic byte_r(input logic nak, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(nak, r);
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
      return x;
   endfunction
   // Kind 0 send byte, 1 write word with check byte, 2 read word ending in a refusal
   task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [1:0] k,
                       input logic [15:0] d, output logic [15:0] q, output logic ak);
      logic       r;
      logic [7:0] pec;
      q = 16'h0000;
      start();
      byte_w({a, 1'b0}, ak);
      byte_w(c, r);
      pec = crc8(crc8(8'h00, {a, 1'b0}), c);
      if (k == 2'd1) begin
         byte_w(d[7:0], r);
         byte_w(d[15:8], r);
         byte_w(crc8(crc8(pec, d[7:0]), d[15:8]), r);
      end
      if (k == 2'd2) begin
         start();
         byte_w({a, 1'b1}, r);
         byte_r(1'b0, q[7:0]);
         byte_r(1'b1, q[15:8]);
      end
      stop();
   endtask
endmodule

/* verif/test_pbr_register_bank.sv */
`timescale 1ns/1ns
module test_pbr_register_bank;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        pclk = 1'b0;
   logic        done = 1'b0;
   logic [15:0] result = 16'h0000;
   wire         scl;
   wire         sda;
   logic        sda_oe;
   logic        alert_oe;
   logic        req;
   logic [7:0]  retries;
   logic [7:0]  bit_time;
   logic [2:0]  idx;
   logic [2:0]  idx_q;
   logic [15:0] q;
   logic        ak;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          reqs = 0;
   // Row: write flag, code, write data, expected read
   logic [43:0] rows [27] = '{
      44'h0_0c_0000_00a5, 44'h0_0d_0000_0203, 44'h0_0e_0000_0000, 44'h0_0f_0000_0000,
      44'h0_10_0000_7fff, 44'h0_13_0000_7fff, 44'h0_09_0000_0001, 44'h0_0a_0000_00ff,
      44'h0_08_0000_0000, 44'h0_07_0000_0000, 44'h1_0d_1234_1234, 44'h1_0f_abcd_00cd,
      44'h1_0f_0000_0000, 44'h1_10_0640_0640, 44'h1_0e_17c0_17c0, 44'h1_08_1234_0000,
      44'h1_0c_00ed_00e5, 44'h0_0e_0000_005f, 44'h1_0c_00a5_00a5, 44'h0_0e_0000_17c0,
      44'h1_0c_03a0_03a0, 44'h0_00_0000_1ec0, 44'h0_01_0000_8000, 44'h0_08_0000_1ec0,
      44'h0_0a_0000_0000, 44'h0_0b_0000_0000, 44'h0_0c_0000_00a5};
   pbr_register_bank #(.POLL_GAP_CYC(50), .I2C_TMO_CYC(200)) dut_u (
      .MCLK(mclk), .RSTN(rstn), .BUS_ADDR_SELECT(1'b1), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(), .SDA_OE(sda_oe), .ALERT_O(), .ALERT_OE(alert_oe), .PECI_RETRIES(retries),
      .PECI_BIT_TIME(bit_time), .PECI_CLK(pclk), .PECI_DONE(done), .PECI_RESULT(result),
      .PECI_RD_REQ(req), .PECI_RD_IDX(idx));
   pbr_host_model host_u (.scl(scl), .sda(sda), .sda_oe(sda_oe));
   always #4 mclk = ~mclk;
   initial begin
      #37;
      forever begin
         #62 pclk = 1'b1;
         #63 pclk = 1'b0;
      end
   end
   ////////////////////////////////////////
   // Link engine: pair 0 reads 28 degrees, others an error code
   always @(posedge pclk) begin
      if (req) begin
         idx_q = idx;
         reqs++;
         repeat (3) @(posedge pclk);
         result <= (idx_q == 3'd0) ? 16'h0700 : 16'h8000;
         done <= 1'b1;
         @(posedge pclk);
         result <= ~result;
         done <= 1'b0;
      end
   end
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic op(input logic [7:0] c, input logic [1:0] k);
      host_u.xfer(7'h55, c, k, rows[0][31:16], q, ak);
      chk("ack", 16'h0000, {15'h0000, ak});
   endtask
   task automatic run(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         if (rows[i][40])
            host_u.xfer(7'h55, rows[i][39:32], 2'd1, rows[i][31:16], q, ak);
         op(rows[i][39:32], 2'd2);
         chk("reg", rows[i][15:0], q);
      end
   endtask
   task automatic wait_alert(input logic v);
      for (int n = 0; n < 5000 && alert_oe !== v; n++) @(negedge mclk);
      chk("alert", {15'h0000, v}, {15'h0000, alert_oe});
      if (alert_oe !== v)
         final_report();
   endtask
   // Long enough for the link side's two-stage reset as well
   task automatic do_reset();
      rstn = 1'b0;
      repeat (6) @(posedge pclk);
      @(negedge mclk);
      rstn = 1'b1;
      repeat (3) @(negedge mclk);
   endtask
   initial begin
      do_reset();
      run(0, 20);
      $display("test registers done");
      op(8'h14, 2'd0);
      wait_alert(1'b1);
      for (int n = 0; n < 5000 && reqs < 2; n++) @(negedge mclk);
      repeat (100) @(negedge mclk);
      chk("reads", 16'h0002, reqs[15:0]);
      run(21, 25);
      chk("link cfg", 16'h1234, {bit_time, retries});
      chk("alert held", 16'h0001, {15'h0000, alert_oe});
      $display("test polling done");
      op(8'h15, 2'd0);
      wait_alert(1'b0);
      op(8'h14, 2'd0);
      wait_alert(1'b1);
      host_u.xfer(7'h54, 8'h0c, 2'd2, 16'h0000, q, ak);
      chk("nack", 16'h0001, {15'h0000, ak});
      do_reset();
      chk("reset", 16'h0406, {bit_time[6:0], retries, alert_oe});
      run(26, 26);
      $display("test reset done");
      final_report();
   end
endmodule
